// file: verilog/afm_monitor.sv
// actuator feedback monitor: channel array, state machines and register port
//
// Overview of operation
// [RQ1] Fourteen independent channels, each self-contained.
// [RQ2] Activation arms; inactive keeps release open.
// [RQ3] Feedback must drop in window after closing.
// [RQ4] Feedback must rise in window after opening.
// [RQ5] Window 0.1-3.0 s, 0.1 s steps, default 3.0.
// [RQ6] Gating optional; default runs without gate input.
// [RQ7] Manual, controlled, automatic restart; manual default.
// [RQ8] Acknowledge resets monitor in manual/controlled modes.
// [RQ9] Release closes only after correct activation, timing.
// [RQ10] Fault output high exactly in error states.
// [RQ11] Timer output shows current window count.
// [RQ12] Codes 0000, 2001, 2003, 2004, 2007 while waiting.
// [RQ13] Codes 8001 released, 801A awaiting feedback open.
// [RQ14] Fault codes F00C, F011, F012.
// [RQ15] Manual closes on rise, controlled on fall.
// [RQ16] Automatic closes once inputs are satisfied.
// [RQ17] Inactive gate keeps channel off, release open.
// [RQ18] Timeout fault cleared only by acknowledge rise.
// [RQ19] Timer counts 0.1 s ticks between transitions.
// [RQ20] Reset opens release, clears fault, shows 0000.
//
// The plain strobed port and the register offsets were left to the implementer.
module afm_monitor #(
  parameter int TICK_CYCLES_P = afm_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [afm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [afm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [afm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [afm_pkg::NUM_CH-1:0] activation_in,
  input wire logic [afm_pkg::NUM_CH-1:0] feedback_in,
  input wire logic [afm_pkg::NUM_CH-1:0] acknowledge_in,
  input wire logic [afm_pkg::NUM_CH-1:0] gate_in,
  output logic [afm_pkg::NUM_CH-1:0] release_out,
  output logic [afm_pkg::NUM_CH-1:0] fault_out,
  output logic [afm_pkg::NUM_CH-1:0][afm_pkg::WIN_W-1:0] timer_value_out,
  output logic [afm_pkg::NUM_CH-1:0][afm_pkg::CODE_W-1:0] state_code_out
);
  import afm_pkg::*;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // word address inside a per-channel block starting at base
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] span;
    span = ADDR_W'(NUM_CH) * REG_STRIDE;
    return (addr[1:0] == 2'h0) && (addr >= base) && (addr < base + span);
  endfunction : addr_hit

  // channel number of an address inside a block
  function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] addr,
                                                  input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] ofs;
    ofs = addr - base;
    return ofs[IDX_W+1:2];
  endfunction : addr_index

  // keep a written window inside the legal step range
  function automatic logic [WIN_W-1:0] clamp_window(input logic [WIN_W-1:0] w);
    if (w < WIN_MIN) begin
      return WIN_MIN;
    end else if (w > WIN_MAX) begin
      return WIN_MAX;
    end
    return w;
  endfunction : clamp_window

  // state entered once the input conditions are clear
  function automatic afm_state_t ready_state(input afm_mode_t mode);
    if (mode == MODE_AUTOMATIC) begin
      return ST_WFB_OPEN; // RQ16
    end
    return ST_ACK_RISE;
  endfunction : ready_state

  // release is closed only in the supervised released states
  function automatic logic is_release(input afm_state_t st);
    return (st == ST_WFB_OPEN) || (st == ST_ON); // RQ9
  endfunction : is_release

  // error states
  function automatic logic is_fault(input afm_state_t st);
    return (st == ST_F_START) || (st == ST_F_OPEN) || (st == ST_F_CLOSE); // RQ10
  endfunction : is_fault

  // state code presented for a state
  function automatic logic [CODE_W-1:0] state_code(input afm_state_t st);
    case (st)
      ST_OFF: return CODE_OFF; // RQ12
      ST_WAIT: return CODE_WAIT_IN; // RQ12
      ST_ACK_RISE: return CODE_ACK_RISE; // RQ12
      ST_ACK_FALL: return CODE_ACK_FALL; // RQ12
      ST_WFB_CLOSE: return CODE_FB_CLOSE; // RQ12
      ST_ON: return CODE_ON; // RQ13
      ST_WFB_OPEN: return CODE_FB_OPEN; // RQ13
      ST_F_START: return CODE_F_START; // RQ14
      ST_F_OPEN: return CODE_F_OPEN; // RQ14
      ST_F_CLOSE: return CODE_F_CLOSE; // RQ14
      default: return CODE_OFF;
    endcase
  endfunction : state_code

  // ---------------------------------------------------------------
  // configuration storage
  // ---------------------------------------------------------------
  logic [WIN_W-1:0] win_reg [NUM_CH]; // window per channel, in ticks
  logic [NUM_CH-1:0] gate_req_reg; // gate input required
  afm_mode_t mode_reg [NUM_CH]; // restart mode per channel
  logic startup_reg; // high only in the first enabled cycle
  logic tick; // one pulse per window step

  // write decode
  logic cfg_wr_hit; // write lands in the config block
  logic [IDX_W-1:0] cfg_wr_idx; // channel of that write

  assign cfg_wr_hit = reg_wr && addr_hit(reg_addr, CFG_BASE);
  assign cfg_wr_idx = addr_index(reg_addr, CFG_BASE);

  // configuration writes; unmapped writes are dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        win_reg[i] <= WIN_RST; // RQ5
        mode_reg[i] <= MODE_RST; // RQ7
      end
      gate_req_reg <= {NUM_CH{GATE_RST}}; // RQ6
    end else if (ce && cfg_wr_hit) begin
      win_reg[cfg_wr_idx] <= clamp_window(reg_wdata[CFG_WIN_LSB +: WIN_W]); // RQ5
      gate_req_reg[cfg_wr_idx] <= reg_wdata[CFG_GATE_BIT]; // RQ6
      // the spare mode code falls back to manual restart
      case (reg_wdata[CFG_MODE_LSB +: 2])
        2'h1: begin
          mode_reg[cfg_wr_idx] <= MODE_CONTROLLED;
        end
        2'h2: begin
          mode_reg[cfg_wr_idx] <= MODE_AUTOMATIC;
        end
        default: begin
          mode_reg[cfg_wr_idx] <= MODE_MANUAL; // RQ7
        end
      endcase
    end
  end

  // startup marker for the simultaneous acknowledge check
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startup_reg <= 1'b1;
    end else if (ce) begin
      startup_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] rd_cfg_idx; // channel of a config read
  logic [IDX_W-1:0] rd_st_idx; // channel of a status read

  assign rd_cfg_idx = addr_index(reg_addr, CFG_BASE);
  assign rd_st_idx = addr_index(reg_addr, STAT_BASE);

  // read data stand for exactly one cycle; unmapped reads give zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RDATA_RST;
    end else if (ce) begin
      reg_rdata <= RDATA_RST;
      if (reg_rd && addr_hit(reg_addr, CFG_BASE)) begin
        reg_rdata[CFG_WIN_LSB +: WIN_W] <= win_reg[rd_cfg_idx];
        reg_rdata[CFG_GATE_BIT] <= gate_req_reg[rd_cfg_idx];
        reg_rdata[CFG_MODE_LSB +: 2] <= mode_reg[rd_cfg_idx];
      end else if (reg_rd && addr_hit(reg_addr, STAT_BASE)) begin
        // live channel state
        reg_rdata[ST_CODE_LSB +: CODE_W] <= state_code_out[rd_st_idx];
        reg_rdata[ST_TIMER_LSB +: WIN_W] <= timer_value_out[rd_st_idx];
        reg_rdata[ST_REL_BIT] <= release_out[rd_st_idx];
        reg_rdata[ST_FLT_BIT] <= fault_out[rd_st_idx];
      end
    end
  end

  // ---------------------------------------------------------------
  // shared window step
  // ---------------------------------------------------------------
  afm_tick #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .tick_out(tick) // RQ19
  );

  // ---------------------------------------------------------------
  // monitor channels
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch // RQ1
    afm_state_t state_reg; // current channel state
    afm_state_t state_next; // next channel state
    logic [WIN_W-1:0] timer_reg; // ticks since last release change
    logic [WIN_W-1:0] timer_next; // next timer value
    logic ack_prev_reg; // acknowledge one cycle ago
    logic armed; // activation present and gate satisfied
    logic fb; // feedback contact closed
    logic ack_rise; // acknowledge picked up
    logic ack_fall; // acknowledge dropped
    logic expired; // window used up

    // activation counts only when the gate allows it
    assign armed = activation_in[c] && (!gate_req_reg[c] || gate_in[c]); // RQ2 RQ17
    assign fb = feedback_in[c];
    assign ack_rise = acknowledge_in[c] && !ack_prev_reg;
    assign ack_fall = !acknowledge_in[c] && ack_prev_reg;
    assign expired = timer_reg >= win_reg[c];

    // acknowledge history for edge detection
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        ack_prev_reg <= 1'b0;
      end else if (ce) begin
        ack_prev_reg <= acknowledge_in[c];
      end
    end

    // next state
    always_comb begin
      state_next = state_reg;
      case (state_reg)
        ST_OFF: begin
          if (startup_reg && activation_in[c] && acknowledge_in[c]) begin
            state_next = ST_F_START; // RQ14
          end else if (armed && fb) begin
            state_next = ready_state(mode_reg[c]); // RQ2
          end else if (armed) begin
            state_next = ST_WAIT;
          end
        end
        ST_WAIT: begin
          // armed but actuator not yet back at rest
          if (!armed) begin
            state_next = ST_OFF; // RQ17
          end else if (fb) begin
            state_next = ready_state(mode_reg[c]); // RQ16
          end
        end
        ST_ACK_RISE: begin
          if (!armed || !fb) begin
            state_next = ST_OFF;
          end else if (mode_reg[c] == MODE_AUTOMATIC) begin
            state_next = ST_WFB_OPEN; // RQ16
          end else if (ack_rise && mode_reg[c] == MODE_CONTROLLED) begin
            state_next = ST_ACK_FALL; // RQ15
          end else if (ack_rise) begin
            state_next = ST_WFB_OPEN; // RQ8 RQ15
          end
        end
        ST_ACK_FALL: begin
          if (!armed || !fb) begin
            state_next = ST_OFF;
          end else if (ack_fall) begin
            state_next = ST_WFB_OPEN; // RQ8 RQ15
          end
        end
        ST_WFB_OPEN: begin
          // a feedback change wins over a timeout in the same cycle
          if (!armed) begin
            state_next = ST_WFB_CLOSE; // RQ2 RQ4
          end else if (!fb) begin
            state_next = ST_ON;
          end else if (expired) begin
            state_next = ST_F_OPEN; // RQ3
          end
        end
        ST_ON: begin
          if (!armed) begin
            state_next = ST_WFB_CLOSE; // RQ4 RQ17
          end
        end
        ST_WFB_CLOSE: begin
          if (fb) begin
            state_next = ST_OFF;
          end else if (expired) begin
            state_next = ST_F_CLOSE; // RQ4
          end
        end
        ST_F_START: begin
          // cleared once acknowledge is let go
          if (!acknowledge_in[c]) begin
            state_next = ST_OFF;
          end
        end
        ST_F_OPEN, ST_F_CLOSE: begin
          if (ack_rise) begin
            state_next = ST_OFF; // RQ18
          end
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end

    // window timer: restart on entering ST_WFB_OPEN or ST_WFB_CLOSE, stop on feedback
    always_comb begin
      timer_next = timer_reg;
      if ((state_next == ST_WFB_OPEN || state_next == ST_WFB_CLOSE) &&
          state_next != state_reg) begin
        timer_next = TIMER_RST; // RQ19
      end else if ((state_reg == ST_WFB_OPEN || state_reg == ST_WFB_CLOSE) &&
                   tick && !expired) begin
        timer_next = timer_reg + WIN_W'(1); // RQ19
      end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        state_reg <= ST_OFF; // RQ20
      end else if (ce) begin
        state_reg <= state_next;
      end
    end

    // timer register and its output
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        timer_reg <= TIMER_RST;
        timer_value_out[c] <= TIMER_RST;
      end else if (ce) begin
        timer_reg <= timer_next;
        timer_value_out[c] <= timer_next; // RQ11
      end
    end

    // channel outputs, registered alongside the state
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        release_out[c] <= 1'b0; // RQ20
        fault_out[c] <= 1'b0; // RQ20
        state_code_out[c] <= CODE_OFF; // RQ20
      end else if (ce) begin
        release_out[c] <= is_release(state_next); // RQ9
        fault_out[c] <= is_fault(state_next); // RQ10
        state_code_out[c] <= state_code(state_next); // RQ12
      end
    end
  end

endmodule : afm_monitor

// file: verilog/afm_pkg.sv
// constants, types and register map shared by the actuator feedback monitor
package afm_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 14; // independent monitor channels
  localparam int WIN_W = 5; // window and timer width, in ticks
  localparam int CODE_W = 16; // state code width
  localparam int ADDR_W = 8; // register address width
  localparam int DATA_W = 32; // register data width
  localparam int CNT_W = 27; // tick prescaler width
  localparam int IDX_W = 4; // channel index width

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // ref_clk period
  localparam int TICK_TIME_MS = 100; // window step
  localparam int TICK_CYCLES = TICK_TIME_MS * 1_000_000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // window limits and reset values, in ticks
  // ---------------------------------------------------------------
  localparam logic [WIN_W-1:0] WIN_MIN = 5'h01; // 0.1 s
  localparam logic [WIN_W-1:0] WIN_MAX = 5'h1e; // 3.0 s
  localparam logic [WIN_W-1:0] WIN_RST = 5'h1e; // 3.0 s after reset
  localparam logic [WIN_W-1:0] TIMER_RST = 5'h00; // timer after reset
  localparam logic GATE_RST = 1'b0; // ungated_operation after reset

  // restart mode encoding
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'h0, // manual_restart
    MODE_CONTROLLED = 2'h1, // controlled_restart
    MODE_AUTOMATIC = 2'h2 // automatic_restart
  } afm_mode_t;
  localparam afm_mode_t MODE_RST = MODE_MANUAL;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word per channel)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_BASE = 8'h00; // config, channel 0
  localparam logic [ADDR_W-1:0] STAT_BASE = 8'h40; // status, channel 0
  localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04; // bytes per channel
  localparam int CFG_WIN_LSB = 0; // window field [4:0]
  localparam int CFG_GATE_BIT = 5; // gate required
  localparam int CFG_MODE_LSB = 6; // restart mode [7:6]
  localparam int ST_CODE_LSB = 0; // state code [15:0]
  localparam int ST_TIMER_LSB = 16; // timer value [20:16]
  localparam int ST_REL_BIT = 24; // release output
  localparam int ST_FLT_BIT = 25; // fault output
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_OFF = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_WAIT_IN = 16'h2001;
  localparam logic [CODE_W-1:0] CODE_ACK_RISE = 16'h2003;
  localparam logic [CODE_W-1:0] CODE_ACK_FALL = 16'h2004;
  localparam logic [CODE_W-1:0] CODE_FB_CLOSE = 16'h2007;
  localparam logic [CODE_W-1:0] CODE_ON = 16'h8001;
  localparam logic [CODE_W-1:0] CODE_FB_OPEN = 16'h801a;
  localparam logic [CODE_W-1:0] CODE_F_START = 16'hf00c;
  localparam logic [CODE_W-1:0] CODE_F_OPEN = 16'hf011;
  localparam logic [CODE_W-1:0] CODE_F_CLOSE = 16'hf012;

  // channel states, gray coded along the usual path
  typedef enum logic [3:0] {
    ST_OFF = 4'h0, // not released
    ST_WAIT = 4'h1, // armed, feedback still open
    ST_ACK_RISE = 4'h3, // waiting acknowledge rise
    ST_ACK_FALL = 4'h2, // waiting acknowledge fall
    ST_WFB_OPEN = 4'h6, // released, feedback must drop
    ST_ON = 4'h7, // released, no fault
    ST_WFB_CLOSE = 4'h5, // opened, feedback must rise
    ST_F_START = 4'h4, // acknowledge and activation at startup
    ST_F_OPEN = 4'hc, // feedback did not open in time
    ST_F_CLOSE = 4'hd // feedback did not close in time
  } afm_state_t;

endpackage : afm_pkg

// file: verilog/afm_tick.sv
// window step tick generator for the actuator feedback monitor
module afm_tick #(
  parameter int TICK_CYCLES_P = afm_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  output logic tick_out
);
  import afm_pkg::*;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES_P - 1);

  logic [CNT_W-1:0] cnt_reg; // cycles into the current step

  // one-cycle pulse at the end of every step
  assign tick_out = ce && (cnt_reg == LAST);

  // free-running count, wraps at the step length
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (cnt_reg == LAST) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

endmodule : afm_tick

// file: bench/afm_monitor_props.sv
// checker for the actuator feedback monitor ports
module afm_monitor_props #(
  parameter int TICK_CYCLES_P = afm_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_rd,
  input wire logic [afm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [afm_pkg::NUM_CH-1:0] activation_in,
  input wire logic [afm_pkg::NUM_CH-1:0] feedback_in,
  input wire logic [afm_pkg::NUM_CH-1:0] acknowledge_in,
  input wire logic [afm_pkg::NUM_CH-1:0] release_out,
  input wire logic [afm_pkg::NUM_CH-1:0] fault_out,
  input wire logic [afm_pkg::NUM_CH-1:0][afm_pkg::WIN_W-1:0] timer_value_out,
  input wire logic [afm_pkg::NUM_CH-1:0][afm_pkg::CODE_W-1:0] state_code_out
);
  import afm_pkg::*;
  // ------------------------------------------
  // checks on channel 0, kept in manual mode, plus reset outputs of all channels and read data
  // ------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RESET_OFF: assert property ($fell(rst) |->
    release_out == '0 && fault_out == '0 && state_code_out == '0)
    else $error("outputs not idle after reset");
  AST_RDATA_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  AST_REL_CAUSE: assert property ($rose(release_out[0]) |->
    $past(activation_in[0]) && $past(acknowledge_in[0]))
    else $error("release closed without activation and acknowledge");
  AST_FAULT_CODE: assert property (
    fault_out[0] == (state_code_out[0][15:12] == 4'hf))
    else $error("fault output disagrees with state code");
  AST_REL_CODE: assert property (release_out[0] ==
    (state_code_out[0] == CODE_ON || state_code_out[0] == CODE_FB_OPEN))
    else $error("release output disagrees with state code");
  AST_FB_DROP: assert property (ce && state_code_out[0] == CODE_FB_OPEN &&
    activation_in[0] && !feedback_in[0] |=> state_code_out[0] == CODE_ON)
    else $error("feedback drop not taken");
  AST_OPEN_TIMEOUT: assert property ($changed(state_code_out[0]) &&
    state_code_out[0] == CODE_F_OPEN |->
    $past(state_code_out[0]) == CODE_FB_OPEN && $past(timer_value_out[0]) != 5'h00)
    else $error("open fault without an expired window");
  AST_TIMER_STEP: assert property ($changed(timer_value_out[0]) |->
    timer_value_out[0] == 5'h00 || timer_value_out[0] == $past(timer_value_out[0]) + 5'h01)
    else $error("timer moved by more than one step");
  AST_TIMER_RESTART: assert property (
    $changed(release_out[0]) && !fault_out[0] |-> timer_value_out[0] == 5'h00)
    else $error("timer not restarted on release change");
  AST_FAULT_CLEAR: assert property ($fell(fault_out[0]) &&
    $past(state_code_out[0]) != CODE_F_START |->
    $past(acknowledge_in[0]) && !$past(acknowledge_in[0], 2))
    else $error("fault cleared without acknowledge rise");
endmodule : afm_monitor_props

bind afm_monitor afm_monitor_props #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_props (
  .ref_clk, .rst, .ce, .reg_rd, .reg_rdata, .activation_in, .feedback_in,
  .acknowledge_in, .release_out, .fault_out, .timer_value_out, .state_code_out
);

// file: bench/afm_contactor.sv
// model of the actuator auxiliary contact behind each channel
module afm_contactor #(
  parameter int FAST = 3,
  parameter int SLOW = 40
) (
  input wire logic ref_clk,
  input wire logic [afm_pkg::NUM_CH-1:0] release_out,
  input wire logic [afm_pkg::NUM_CH-1:0] slow,
  output logic [afm_pkg::NUM_CH-1:0] feedback_in
);
  import afm_pkg::*;
  // ------------------------------------------
  // contact history, closed at rest
  // ------------------------------------------
  logic [NUM_CH-1:0] hist [SLOW]; // inverted release, oldest last
  initial begin
    foreach (hist[i]) hist[i] = '1;
  end
  // closed release opens the contact, open release lets it close
  always @(posedge ref_clk) begin
    hist[0] <= ~release_out;
    for (int i = 1; i < SLOW; i++) begin
      hist[i] <= hist[i-1];
    end
  end
  // a slow contact outlasts a short window and provokes a timeout
  always_comb begin
    feedback_in = (hist[FAST-1] & ~slow) | (hist[SLOW-1] & slow);
  end
endmodule : afm_contactor

// file: bench/tb_top.sv
// self-checking bench for the actuator feedback monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import afm_pkg::*;
  // ------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------
  localparam int TICK = 10; // short step: a window is a few dozen cycles
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [NUM_CH-1:0] act = 14'h0002; // channel 1 pressed for startup
  logic [NUM_CH-1:0] ack = 14'h0002;
  logic [NUM_CH-1:0] gate = '0;
  logic [NUM_CH-1:0] slow = '0;
  logic [NUM_CH-1:0] fb, rel, flt;
  logic [NUM_CH-1:0][WIN_W-1:0] tmr;
  logic [NUM_CH-1:0][CODE_W-1:0] code;
  logic [31:0] rd;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  afm_monitor #(.TICK_CYCLES_P(TICK)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .activation_in(act), .feedback_in(fb), .acknowledge_in(ack), .gate_in(gate),
    .release_out(rel), .fault_out(flt), .timer_value_out(tmr), .state_code_out(code)
  );
  afm_contactor u_fb (
    .ref_clk(ref_clk), .release_out(rel), .slow(slow), .feedback_in(fb)
  );
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // poll a channel's state code, bounded
  task automatic wait_code(input int ch, input logic [CODE_W-1:0] c);
    int n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (code[ch] !== c && n < 100);
    chk(32'(code[ch]), 32'(c));
  endtask : wait_code
  task automatic set_act(input int ch, input logic b);
    @(posedge ref_clk);
    act[ch] <= b;
  endtask : set_act
  task automatic set_ack(input int ch, input logic b);
    @(posedge ref_clk);
    ack[ch] <= b;
  endtask : set_ack
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  task automatic note(input string s);
    $display("test done: %s", s);
  endtask : note
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ------------------------------------------
  // test sequence
  // ------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    chk({4'h0, rel, flt}, 32'h0);
    chk(32'(code[0]), 32'h0);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    wait_code(1, CODE_F_START);
    chk(32'(flt[1]), 32'h1);
    set_act(1, 1'b0);
    set_ack(1, 1'b0);
    wait_code(1, CODE_OFF);
    note("startup");
    reg_read(CFG_BASE, rd);
    chk(rd, 32'h1e);
    reg_read(8'h80, rd);
    chk(rd, 32'h0);
    reg_write(CFG_BASE, 32'h03); // manual, 0.3 s
    reg_write(CFG_BASE + 8'h04, 32'h43); // controlled
    reg_write(CFG_BASE + 8'h08, 32'h23); // manual, gated
    reg_write(CFG_BASE + 8'h0c, 32'h83); // automatic
    reg_write(CFG_BASE + 8'h10, 32'h00); // window too short
    reg_write(CFG_BASE + 8'h14, 32'hdf); // window too long, mode 3
    reg_read(CFG_BASE + 8'h10, rd);
    chk(rd, 32'h01);
    reg_read(CFG_BASE + 8'h14, rd);
    chk(rd, 32'h1e);
    reg_read(CFG_BASE + 8'h34, rd);
    chk(rd, 32'h1e);
    note("config");
    set_act(0, 1'b1);
    wait_code(0, CODE_ACK_RISE);
    set_ack(0, 1'b1);
    wait_code(0, CODE_FB_OPEN);
    chk(32'({rel[0], tmr[0]}), 32'h20);
    set_ack(0, 1'b0);
    wait_code(0, CODE_ON);
    reg_read(STAT_BASE, rd);
    chk(rd & 32'h0300_ffff, 32'h0100_8001);
    set_act(0, 1'b0);
    wait_code(0, CODE_FB_CLOSE);
    wait_code(0, CODE_OFF);
    note("manual");
    set_act(1, 1'b1);
    wait_code(1, CODE_ACK_RISE);
    set_ack(1, 1'b1);
    wait_code(1, CODE_ACK_FALL);
    set_ack(1, 1'b0);
    wait_code(1, CODE_FB_OPEN);
    wait_code(1, CODE_ON);
    note("controlled");
    set_act(3, 1'b1);
    wait_code(3, CODE_FB_OPEN);
    wait_code(3, CODE_ON);
    repeat (50) @(posedge ref_clk);
    slow[3] <= 1'b1;
    set_act(3, 1'b0);
    wait_code(3, CODE_FB_CLOSE);
    wait_code(3, CODE_F_CLOSE);
    chk(32'({flt[3], rel[3]}), 32'h2);
    repeat (50) @(posedge ref_clk);
    chk(32'(code[3]), 32'(CODE_F_CLOSE));
    set_ack(3, 1'b1);
    wait_code(3, CODE_OFF);
    set_ack(3, 1'b0);
    note("automatic");
    set_act(2, 1'b1);
    set_ack(2, 1'b1);
    set_ack(2, 1'b0);
    repeat (10) @(posedge ref_clk);
    gate[2] <= 1'b1;
    #1;
    chk(32'({rel[2], code[2]}), 32'h0);
    wait_code(2, CODE_ACK_RISE);
    note("gate");
    @(posedge ref_clk);
    slow[0] <= 1'b1;
    set_act(0, 1'b1);
    wait_code(0, CODE_ACK_RISE);
    set_ack(0, 1'b1);
    wait_code(0, CODE_FB_OPEN);
    set_ack(0, 1'b0);
    wait_code(0, CODE_F_OPEN);
    reg_read(STAT_BASE, rd);
    chk(rd & 32'h0300_ffff, 32'h0200_f011);
    set_act(0, 1'b0);
    repeat (50) @(posedge ref_clk);
    chk(32'(code[0]), 32'(CODE_F_OPEN));
    set_ack(0, 1'b1);
    wait_code(0, CODE_OFF);
    note("timeout");
    give_verdict();
  end
endmodule : tb_top
